// ### design/thermal_event_monitor_regs.vh
// Purpose: register map, field positions, reset values and timing of the thermal event monitor
// Assumes: register index times four gives the Wishbone byte address
// Notes:   all data sits in byte lane 0, upper bits read as zero
`ifndef THERMAL_EVENT_MONITOR_REGS_VH
`define THERMAL_EVENT_MONITOR_REGS_VH

// register indices
`define IDX_CONFIG6         8'h10
`define IDX_CONFIG7         8'h11
`define IDX_STATUS2         8'h42
`define IDX_R1_CRIT_LIMIT   8'h6a
`define IDX_LOC_CRIT_LIMIT  8'h6b
`define IDX_R2_CRIT_LIMIT   8'h6c
`define IDX_MASK1           8'h74
`define IDX_MASK2           8'h75
`define IDX_CONFIG3         8'h78
`define IDX_EVENT_TIMER     8'h79
`define IDX_TIMER_LIMIT     8'h7a
`define IDX_CONFIG5         8'h7c
`define IDX_CONFIG4         8'h7d

// field positions
`define BIT_STATUS2_TLIMIT  5
`define BIT_MASK2_TLIMIT    5
`define BIT_MASK1_THERMAL_EVENT_PIN     0
`define BIT_CFG3_THERMAL_EVENT_PIN_EN   1
`define BIT_CFG3_FULL_SPEED 2
`define BIT_CFG4_FUNC_OFF   2
`define BIT_CFG4_DUTY_MAX   3
`define BIT_CFG5_OFFSET64   0
`define BIT_CFG6_MANUAL_OK  3
`define BIT_CFG7_HYST_OFF   0
`define CFG5_CH_EN_LSB      5
`define PIN_FUNC_THERMAL_EVENT_PIN      2'b10

// reset values and full-scale duty
`define RST_ZERO            8'h00
`define RST_CRIT_LIMIT      8'h64
`define DUTY_FULL           8'hff

// disable thresholds of the critical limit, per format
`define CRIT_OFF_OFFSET64   8'h01
`define CRIT_OFF_TWOS       8'h80

// timer resolution
`define TIMER_LSB_NS        22760000
`define CLK_PERIOD_NS       50
`define TIMER_LSB_CYCLES    (`TIMER_LSB_NS / `CLK_PERIOD_NS)

`endif

// ### design/thermal_event_pin_event_timer.v
// Purpose: cumulative assertion timer with saturation and clear on read
// Assumes: assert_in is already synchronised to clk_sys_in
// Notes:   value is 1 from first assertion until two resolution steps pass
`timescale 1ns/1ps
`include "thermal_event_monitor_regs.vh"

module thermal_event_pin_event_timer #(
  parameter TICK_CYCLES = `TIMER_LSB_CYCLES
) (
  // clock and reset
  input  wire       clk_sys_in,
  input  wire       rst_in,
  // control
  input  wire       assert_in,
  input  wire       clear_in,
  // state
  output wire [7:0] value_out
);

  reg  [19:0] prescale;
  reg  [7:0]  ticks;
  reg         seen;
  wire        tick_done = (prescale == TICK_CYCLES[19:0] - 20'h0_0001);

  // accumulate assertion time, saturate at full scale
  // RQ23: accumulate, clear, saturate
  always @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      prescale <= 20'h0_0000;
      ticks    <= 8'h00;
      seen     <= 1'b0;
    end
    else if (clear_in)
    begin
      // RQ25: restart on read
      prescale <= 20'h0_0000;
      ticks    <= 8'h00;
      seen     <= assert_in;
    end
    else if (assert_in)
    begin
      seen     <= 1'b1;
      prescale <= tick_done ? 20'h0_0000 : prescale + 20'h0_0001;
      if (tick_done && ticks != 8'hff)
        ticks <= ticks + 8'h01;
    end
  end

  // RQ24: bit 0 on first assertion
  assign value_out = (seen && ticks == 8'h00) ? 8'h01 : ticks;

endmodule // thermal_event_pin_event_timer

// ### design/crit_temp_channel.v
// Purpose: critical temperature comparison for one channel
// Assumes: temperature carries two fraction bits, updated once per monitoring cycle
// Notes:   condition changes on update_in, or clears at once when disabled, so a trip lasts a whole cycle
`timescale 1ns/1ps
`include "thermal_event_monitor_regs.vh"

module crit_temp_channel (
  // clock and reset
  input  wire       clk_sys_in,
  input  wire       rst_in,
  // measurement
  input  wire [9:0] temp_in,
  input  wire       update_in,
  // configuration
  input  wire [7:0] limit_in,
  input  wire       enable_in,
  input  wire       offset64_in,
  input  wire       hyst_off_in,
  // result
  output reg        active_out
);

  wire [9:0] limit_q   = {limit_in, 2'b00};
  wire [9:0] trip_q    = limit_q + 10'h001;
  // compare in offset form so both formats order as unsigned
  wire [9:0] temp_u    = offset64_in ? temp_in : (temp_in ^ 10'h200);
  wire [9:0] limit_u   = offset64_in ? limit_q : (limit_q ^ 10'h200);
  wire [9:0] trip_u    = offset64_in ? trip_q : (trip_q ^ 10'h200);
  // RQ16: very low limit disables
  wire       limit_off = offset64_in ? (limit_in <= `CRIT_OFF_OFFSET64)
                                     : (limit_in == `CRIT_OFF_TWOS);
  wire       above     = (temp_u >= trip_u);
  wire       at_below  = (temp_u <= limit_u);

  // set at limit plus 0.25, clear at or below limit
  always @(posedge clk_sys_in)
  begin
    if (rst_in)
      active_out <= 1'b0;
    else if (!enable_in || limit_off)
      active_out <= 1'b0;
    else if (update_in)
    begin
      // RQ11: trip above limit
      if (above)
        active_out <= 1'b1;
      // RQ12: hold until at or below
      else if (hyst_off_in || at_below)
        active_out <= 1'b0;
    end
  end

endmodule // crit_temp_channel

// ### design/thermal_event_monitor.v
// Purpose: thermal event pin monitor, timer limit alert, pin drive and fan override
// Assumes: temperatures and fan state arrive from logic on clk_sys_in
// Notes:   pin inputs pass two flip-flops; registers sit on classic Wishbone
//          timer step is a parameter for short benches
//          only the main pin is driven
//          no interrupt logic beyond the alert
//
// Contract
// RQ1: eight-bit limit for accumulated event time
// RQ2: compare timer against limit continuously
// RQ3: timer above limit sets flag, raises alert
// RQ4: mask gates only alert, flag still sets
// RQ5: zero limit alerts on first assertion
// RQ6: limit one alerts after 45.52 ms
// RQ7: timer monitoring needs enable bit, off after reset
// RQ8: full-speed bit forces 100% while asserted
// RQ9: bit clear leaves fans unchanged
// RQ10: stopped fans are never raised
// RQ11: drive pin low above limit plus 0.25
// RQ12: hold low until at or below limit
// RQ13: low for at least one monitoring cycle
// RQ14: three critical limits at consecutive addresses
// RQ15: per-channel output enables in config five
// RQ16: very low limit disables that channel
// RQ17: config seven bit zero disables hysteresis
// RQ18: hysteresis on, function off: no drive
// RQ19: hysteresis off, function off: still drives
// RQ20: manual mode needs config six bit three
// RQ21: config four bit three selects duty
// RQ22: config four bit two blocks fan change
// RQ23: timer accumulates, clears on read, saturates
// RQ24: bit zero first, then 22.76 ms steps
// RQ25: read during assertion restarts with bit zero
// RQ26: flags sticky until gone and read
// RQ27: channel conditions combined by OR
//
// The Wishbone slave port was decided locally.
`timescale 1ns/1ps
`include "thermal_event_monitor_regs.vh"

module thermal_event_monitor #(
  parameter TIMER_TICK_CYCLES = `TIMER_LSB_CYCLES
) (
  // clock and reset
  input  wire        clk_sys_in,
  input  wire        rst_in,
  // wishbone slave
  input  wire        wb_cyc_in,
  input  wire        wb_stb_in,
  input  wire        wb_we_in,
  input  wire [8:0]  wb_adr_in,
  input  wire [3:0]  wb_sel_in,
  input  wire [31:0] wb_dat_in,
  output reg  [31:0] wb_dat_out,
  output reg         wb_ack_out,
  // thermal event pins
  input  wire        thermal_event_pin_n_in,
  output reg         thermal_event_pin_out,
  output reg         thermal_event_pin_oe_out,
  input  wire        shared_pin_n_in,
  // temperatures, two fraction bits
  input  wire [9:0]  temp_remote1_in,
  input  wire [9:0]  temp_local_in,
  input  wire [9:0]  temp_remote2_in,
  input  wire [2:0]  temp_update_in,
  // fan control
  input  wire [7:0]  fan_duty_in,
  input  wire [7:0]  fan_max_duty_in,
  input  wire        fan_running_in,
  input  wire        fan_manual_in,
  output reg  [7:0]  fan_duty_out,
  // alert
  output reg         smbus_alert_n_out
);

  // software registers
  reg  [7:0] crit_limit [0:2];
  reg  [7:0] event_timer_limit;
  reg  [7:0] config3;
  reg  [7:0] config4;
  reg  [7:0] config5;
  reg  [7:0] config6;
  reg  [7:0] config7;
  reg  [7:0] mask1;
  reg  [7:0] mask2;
  reg        timer_limit_status_flag;

  // pin synchronisers
  reg  [1:0] main_pin_sync;
  reg  [1:0] shared_pin_sync;

  // bus decode
  // ack low gates the request: one answer each
  wire       bus_req  = wb_cyc_in && wb_stb_in && !wb_ack_out;
  wire [7:0] reg_idx  = {1'b0, wb_adr_in[8:2]};
  wire       bus_wr   = bus_req && wb_we_in && wb_sel_in[0];
  wire       bus_rd   = bus_req && !wb_we_in;
  wire [7:0] wr_byte  = wb_dat_in[7:0];

  // pin function decode
  // shared pin counts only in thermal setting
  wire [1:0] shared_pin_function_select = config4[1:0];
  wire       thermal_event_pin_enabled  = config3[`BIT_CFG3_THERMAL_EVENT_PIN_EN];
  wire       shared_is_thermal_event_pin = (shared_pin_function_select == `PIN_FUNC_THERMAL_EVENT_PIN);

  // timer and comparison
  wire [7:0] timer_value;
  wire       timer_read   = bus_rd && (reg_idx == `IDX_EVENT_TIMER);
  wire       status_read  = bus_rd && (reg_idx == `IDX_STATUS2);
  wire       pin_asserted;
  wire       limit_exceeded;
  wire       alert_masked;

  // channel and override terms
  wire [2:0] ch_active;
  wire [29:0] temps = {temp_remote2_in, temp_local_in, temp_remote1_in};
  wire       any_active;
  wire       drive_allowed;
  wire       full_speed_on_assert;

  // two-flop synchronisers for the external pins
  // reset to idle high: no false event
  always @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      main_pin_sync   <= 2'b11;
      shared_pin_sync <= 2'b11;
    end
    else
    begin
      main_pin_sync   <= {main_pin_sync[0], thermal_event_pin_n_in};
      shared_pin_sync <= {shared_pin_sync[0], shared_pin_n_in};
    end
  end

  // either pin low feeds the one timer
  // RQ7: monitoring only with enable bit
  assign pin_asserted = thermal_event_pin_enabled &&
                        (!main_pin_sync[1] || (shared_is_thermal_event_pin && !shared_pin_sync[1]));

  // accumulating timer
  // a read restarts the count; an ongoing
  // event shows 1 again at once
  thermal_event_pin_event_timer #(
    .TICK_CYCLES (TIMER_TICK_CYCLES)
  ) u_timer (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .assert_in  (pin_asserted),
    .clear_in   (timer_read),
    .value_out  (timer_value)
  );

  // strict compare: 1 beats a zero limit
  // RQ2: continuous compare
  // RQ5: zero limit trips at value one
  // RQ6: limit one trips at two steps
  assign limit_exceeded = (timer_value > event_timer_limit);

  // other pin's mask bit has no effect
  // RQ4: mask bit chosen by pin in use
  assign alert_masked = shared_is_thermal_event_pin ? mask2[`BIT_MASK2_TLIMIT]
                                        : mask1[`BIT_MASK1_THERMAL_EVENT_PIN];

  // sticky timer limit flag, set wins over read
  // excess in the read cycle is never lost
  // set one edge after the limit is passed
  always @(posedge clk_sys_in)
  begin
    if (rst_in)
      timer_limit_status_flag <= 1'b0;
    // RQ3: flag on limit excess
    else if (limit_exceeded)
      timer_limit_status_flag <= 1'b1;
    // RQ26: clear only after read
    else if (status_read)
      timer_limit_status_flag <= 1'b0;
  end

  // alert output, active low
  // low while the flag stands and its mask bit is clear
  always @(posedge clk_sys_in)
  begin
    if (rst_in)
      smbus_alert_n_out <= 1'b1;
    else
      // RQ4: mask gates alert only
      smbus_alert_n_out <= !(timer_limit_status_flag && !alert_masked);
  end

  // per-channel critical temperature conditions
  // format and hysteresis shared by all
  // trip, hold and disable in the channel
  genvar ch;
  generate
    for (ch = 0; ch < 3; ch = ch + 1)
    begin : g_chan
      // RQ15: channel enable bits
      crit_temp_channel u_chan (
        .clk_sys_in  (clk_sys_in),
        .rst_in      (rst_in),
        .temp_in     (temps[ch*10 +: 10]),
        .update_in   (temp_update_in[ch]),
        .limit_in    (crit_limit[ch]),
        .enable_in   (config5[`CFG5_CH_EN_LSB + ch]),
        .offset64_in (config5[`BIT_CFG5_OFFSET64]),
        .hyst_off_in (config7[`BIT_CFG7_HYST_OFF]),
        .active_out  (ch_active[ch])
      );
    end
  endgenerate

  // RQ27: OR of channel conditions
  assign any_active = |ch_active;

  // function-off blocks pin only with hysteresis
  // RQ17: hysteresis off bit
  // RQ18: function off blocks drive
  // RQ19: unless hysteresis is off
  assign drive_allowed = thermal_event_pin_enabled &&
                         (!config4[`BIT_CFG4_FUNC_OFF] || config7[`BIT_CFG7_HYST_OFF]);

  // open-drain pin drive
  // value stays low, enable pulls the pin
  always @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      thermal_event_pin_out    <= 1'b0;
      thermal_event_pin_oe_out <= 1'b0;
    end
    else
    begin
      thermal_event_pin_out    <= 1'b0;
      // RQ11: pull pin low
      // RQ13: condition lasts a cycle
      thermal_event_pin_oe_out <= any_active && drive_allowed;
    end
  end

  // full speed override decision
  // stopped fans stay stopped
  // RQ8: full speed while asserted
  // RQ10: only when already running
  // RQ20: manual mode permission
  // RQ22: function off blocks fans
  assign full_speed_on_assert = pin_asserted && config3[`BIT_CFG3_FULL_SPEED] &&
                 fan_running_in && !config4[`BIT_CFG4_FUNC_OFF] &&
                 (!fan_manual_in || config6[`BIT_CFG6_MANUAL_OK]);

  // fan duty output
  // registered: applied duty never glitches
  always @(posedge clk_sys_in)
  begin
    if (rst_in)
      fan_duty_out <= `RST_ZERO;
    // RQ21: full or programmed maximum
    else if (full_speed_on_assert)
      fan_duty_out <= config4[`BIT_CFG4_DUTY_MAX] ? fan_max_duty_in : `DUTY_FULL;
    // RQ9: otherwise pass through
    else
      fan_duty_out <= fan_duty_in;
  end

  // register writes
  // timer and status are read only
  // a write needs byte lane 0
  always @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      // limits start high, no early trip
      crit_limit[0]     <= `RST_CRIT_LIMIT;
      crit_limit[1]     <= `RST_CRIT_LIMIT;
      crit_limit[2]     <= `RST_CRIT_LIMIT;
      event_timer_limit <= `RST_ZERO;
      // RQ7: monitoring off after reset
      config3           <= `RST_ZERO;
      config4           <= `RST_ZERO;
      config5           <= `RST_ZERO;
      config6           <= `RST_ZERO;
      config7           <= `RST_ZERO;
      mask1             <= `RST_ZERO;
      mask2             <= `RST_ZERO;
    end
    else if (bus_wr)
    begin
      case (reg_idx)
        // RQ14: consecutive critical limits
        `IDX_R1_CRIT_LIMIT:  crit_limit[0] <= wr_byte;
        `IDX_LOC_CRIT_LIMIT: crit_limit[1] <= wr_byte;
        `IDX_R2_CRIT_LIMIT:  crit_limit[2] <= wr_byte;
        // RQ1: eight-bit timer limit
        `IDX_TIMER_LIMIT:    event_timer_limit <= wr_byte;
        // configuration and mask bytes
        `IDX_CONFIG3:        config3 <= wr_byte;
        `IDX_CONFIG4:        config4 <= wr_byte;
        `IDX_CONFIG5:        config5 <= wr_byte;
        `IDX_CONFIG6:        config6 <= wr_byte;
        `IDX_CONFIG7:        config7 <= wr_byte;
        `IDX_MASK1:          mask1 <= wr_byte;
        `IDX_MASK2:          mask2 <= wr_byte;
        default:             ;
      endcase
    end
  end

  // read data and acknowledge, one wait cycle
  // data is zero outside the ack cycle
  always @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_out <= bus_req;
      wb_dat_out <= 32'h0000_0000;
      if (bus_rd)
      begin
        case (reg_idx)
          `IDX_R1_CRIT_LIMIT:  wb_dat_out[7:0] <= crit_limit[0];
          `IDX_LOC_CRIT_LIMIT: wb_dat_out[7:0] <= crit_limit[1];
          `IDX_R2_CRIT_LIMIT:  wb_dat_out[7:0] <= crit_limit[2];
          `IDX_TIMER_LIMIT:    wb_dat_out[7:0] <= event_timer_limit;
          // read-only views
          `IDX_EVENT_TIMER:    wb_dat_out[7:0] <= timer_value;
          `IDX_STATUS2:        wb_dat_out[`BIT_STATUS2_TLIMIT] <= timer_limit_status_flag;
          `IDX_CONFIG3:        wb_dat_out[7:0] <= config3;
          `IDX_CONFIG4:        wb_dat_out[7:0] <= config4;
          `IDX_CONFIG5:        wb_dat_out[7:0] <= config5;
          `IDX_CONFIG6:        wb_dat_out[7:0] <= config6;
          `IDX_CONFIG7:        wb_dat_out[7:0] <= config7;
          `IDX_MASK1:          wb_dat_out[7:0] <= mask1;
          `IDX_MASK2:          wb_dat_out[7:0] <= mask2;
          default:             wb_dat_out <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule // thermal_event_monitor

// ### tb/thermal_event_pin_partner.sv
// Purpose: processor hot source on the thermal pin
// Assumes: pin is open drain with a pull-up
// Notes:   our pull and the device drive are wired together
`timescale 1ns/1ps

module thermal_event_pin_partner (
  // clock
  input  wire clk_sys_in,
  // device drive of the pin
  input  wire pin_oe_in,
  // wired pin level
  output wire pin_n_out
);
  reg hot;

  // idle high by pull-up, low if anyone pulls
  assign pin_n_out = !(hot || pin_oe_in);

  // pull the pin low for n cycles
  task pulse(input integer n);
    begin
      @(posedge clk_sys_in);
      hot <= 1'b1;
      repeat (n) @(posedge clk_sys_in);
      hot <= 1'b0;
    end
  endtask

  initial hot = 1'b0;
endmodule // thermal_event_pin_partner

// ### tb/thermal_event_monitor_chk.sv
// Purpose: port checks of the thermal event monitor
// Assumes: bound to every monitor instance
// Notes:   pin drive changes trace to a strobe or a write
`timescale 1ns/1ps

module thermal_event_monitor_chk (
  // clock and reset
  input wire        clk_sys_in,
  input wire        rst_in,
  // bus
  input wire        wb_cyc_in,
  input wire        wb_stb_in,
  input wire [31:0] wb_dat_out,
  input wire        wb_ack_out,
  // pin and channels
  input wire        thermal_event_pin_out,
  input wire        thermal_event_pin_oe_out,
  input wire [2:0]  temp_update_in,
  // fans
  input wire [7:0]  fan_duty_in,
  input wire        fan_running_in,
  input wire [7:0]  fan_duty_out
);
  wire any_upd;

  // any channel update strobe
  assign any_upd = |temp_update_in;

  default clocking @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);

  a_ack_single: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  a_ack_answers: assert property ((wb_cyc_in && wb_stb_in && !wb_ack_out) |=> wb_ack_out)
    else $error("request not answered next cycle");
  a_dat_idle: assert property (!wb_ack_out |-> wb_dat_out == 32'h0000_0000)
    else $error("read data not zero outside ack");
  a_dat_upper: assert property (wb_dat_out[31:8] == 24'h00_0000)
    else $error("read data upper bits set");
  a_pin_level: assert property (thermal_event_pin_out == 1'b0)
    else $error("pin output value not low");
  a_duty_stopped: assert property ((!$past(rst_in) && !$past(fan_running_in))
    |-> fan_duty_out == $past(fan_duty_in))
    else $error("stopped fans changed");
  a_oe_rise_cause: assert property ($rose(thermal_event_pin_oe_out)
    |-> ($past(any_upd, 2) || $past(wb_ack_out, 1) || $past(wb_ack_out, 2)
    || $past(wb_ack_out, 3)))
    else $error("pin drive rose without cause");
  a_oe_fall_cause: assert property ($fell(thermal_event_pin_oe_out)
    |-> ($past(any_upd, 2) || $past(wb_ack_out, 1) || $past(wb_ack_out, 2)
    || $past(wb_ack_out, 3)))
    else $error("pin drive fell between updates");
endmodule // thermal_event_monitor_chk

bind thermal_event_monitor thermal_event_monitor_chk thermal_event_monitor_chk_inst (
  .clk_sys_in               (clk_sys_in),
  .rst_in                   (rst_in),
  .wb_cyc_in                (wb_cyc_in),
  .wb_stb_in                (wb_stb_in),
  .wb_dat_out               (wb_dat_out),
  .wb_ack_out               (wb_ack_out),
  .thermal_event_pin_out    (thermal_event_pin_out),
  .thermal_event_pin_oe_out (thermal_event_pin_oe_out),
  .temp_update_in           (temp_update_in),
  .fan_duty_in              (fan_duty_in),
  .fan_running_in           (fan_running_in),
  .fan_duty_out             (fan_duty_out)
);

// ### tb/tb_thermal_event_monitor.sv
// Purpose: register level test of the thermal event monitor
// Assumes: short timer step of 8 cycles
// Notes:   pin is wired with the partner model
`timescale 1ns/1ps

module tb_thermal_event_monitor;
  reg         clk_sys_in;
  reg         rst_in;
  reg         wb_cyc_in;
  reg         wb_stb_in;
  reg         wb_we_in;
  reg  [8:0]  wb_adr_in;
  reg  [3:0]  wb_sel_in;
  reg  [31:0] wb_dat_in;
  wire [31:0] wb_dat_out;
  wire        wb_ack_out;
  wire        pin_n;
  wire        pin_oe;
  wire        pin_val;
  reg         shared_n;
  reg  [9:0]  temp [0:2];
  reg  [2:0]  temp_update_in;
  reg  [7:0]  fan_duty_in;
  reg  [7:0]  fan_max_duty_in;
  reg         fan_running_in;
  reg         fan_manual_in;
  wire [7:0]  fan_duty_out;
  wire        alert_n;
  integer     mismatches;
  integer     num_checks;
  reg  [7:0]  rdat;

  thermal_event_monitor #(.TIMER_TICK_CYCLES(8)) thermal_event_monitor_inst (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
    .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
    .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
    .thermal_event_pin_n_in(pin_n), .thermal_event_pin_out(pin_val),
    .thermal_event_pin_oe_out(pin_oe), .shared_pin_n_in(shared_n),
    .temp_remote1_in(temp[0]), .temp_local_in(temp[1]), .temp_remote2_in(temp[2]),
    .temp_update_in(temp_update_in), .fan_duty_in(fan_duty_in),
    .fan_max_duty_in(fan_max_duty_in), .fan_running_in(fan_running_in),
    .fan_manual_in(fan_manual_in), .fan_duty_out(fan_duty_out),
    .smbus_alert_n_out(alert_n)
  );

  thermal_event_pin_partner thermal_event_pin_partner_inst (
    .clk_sys_in(clk_sys_in), .pin_oe_in(pin_oe), .pin_n_out(pin_n)
  );

  // 20 MHz clock
  initial
  begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end

  task chk8(input string nm, input [7:0] e, input [7:0] g);
    begin
      num_checks = num_checks + 1;
      if (g !== e)
      begin
        mismatches = mismatches + 1;
        $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
    end
  endtask

  // one classic cycle, waits for ack
  task wb(input we, input [7:0] idx, input [7:0] d);
    begin
      @(posedge clk_sys_in);
      wb_cyc_in <= 1'b1;
      wb_stb_in <= 1'b1;
      wb_we_in  <= we;
      wb_adr_in <= {idx[6:0], 2'b00};
      wb_dat_in <= {24'h00_0000, d};
      @(posedge clk_sys_in);
      while (wb_ack_out !== 1'b1)
        @(posedge clk_sys_in);
      rdat = wb_dat_out[7:0];
      wb_cyc_in <= 1'b0;
      wb_stb_in <= 1'b0;
    end
  endtask

  task rd(input [7:0] idx, input [7:0] e, input string nm);
    begin
      wb(1'b0, idx, 8'h00);
      chk8(nm, e, rdat);
    end
  endtask

  // read timer, then clear the flag
  task drain(input [7:0] e);
    begin
      rd(8'h79, e, "timer");
      wb(1'b0, 8'h42, 8'h00);
      rd(8'h42, 8'h00, "status");
    end
  endtask

  // one pin event with given fan setup
  task fan(input [7:0] c3, input [7:0] c4, input [7:0] c6, input run, input man,
           input [7:0] e);
    begin
      wb(1'b1, 8'h78, c3);
      wb(1'b1, 8'h7d, c4);
      wb(1'b1, 8'h10, c6);
      fan_running_in <= run;
      fan_manual_in  <= man;
      fork
        thermal_event_pin_partner_inst.pulse(10);
        begin
          repeat (6) @(posedge clk_sys_in);
          chk8("duty", e, fan_duty_out);
        end
      join
      repeat (5) @(posedge clk_sys_in);
      chk8("duty_after", 8'h40, fan_duty_out);
    end
  endtask

  // new measurement on one channel
  task ts(input integer ch, input [9:0] t, input e);
    begin
      @(posedge clk_sys_in);
      temp[ch] <= t;
      temp_update_in <= 3'b001 << ch;
      @(posedge clk_sys_in);
      temp_update_in <= 3'b000;
      repeat (3) @(posedge clk_sys_in);
      chk8("pin_oe", {7'h00, e}, {7'h00, pin_oe});
    end
  endtask

  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask

  // watchdog
  initial
  begin
    repeat (20000) @(posedge clk_sys_in);
    mismatches = mismatches + 1;
    tally_and_finish;
  end

  // main sequence
  initial
  begin
    mismatches = 0;
    num_checks = 0;
    rst_in = 1'b1;
    {wb_cyc_in, wb_stb_in, wb_we_in} = 3'b000;
    wb_adr_in = 9'h000;
    wb_sel_in = 4'h1;
    wb_dat_in = 32'h0000_0000;
    temp[0] = 10'h000;
    temp[1] = 10'h000;
    temp[2] = 10'h000;
    temp_update_in = 3'b000;
    shared_n = 1'b1;
    fan_duty_in = 8'h40;
    fan_max_duty_in = 8'h80;
    fan_running_in = 1'b1;
    fan_manual_in = 1'b0;
    repeat (5) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    @(posedge clk_sys_in);
    rd(8'h6a, 8'h64, "crit_r1");
    rd(8'h6c, 8'h64, "crit_r2");
    rd(8'h7a, 8'h00, "timer_limit");
    rd(8'h20, 8'h00, "unmapped");
    wb(1'b1, 8'h6b, 8'h55);
    rd(8'h6b, 8'h55, "crit_loc");
    wb_sel_in <= 4'h0;
    wb(1'b1, 8'h6b, 8'haa);
    wb_sel_in <= 4'h1;
    rd(8'h6b, 8'h55, "crit_sel");
    thermal_event_pin_partner_inst.pulse(20);
    rd(8'h79, 8'h00, "timer_off");
    wb(1'b1, 8'h78, 8'h02);
    thermal_event_pin_partner_inst.pulse(3);
    repeat (6) @(posedge clk_sys_in);
    chk8("alert", 8'h00, {7'h00, alert_n});
    rd(8'h42, 8'h20, "status");
    drain(8'h01);
    chk8("alert", 8'h01, {7'h00, alert_n});
    wb(1'b1, 8'h74, 8'h01);
    thermal_event_pin_partner_inst.pulse(3);
    repeat (6) @(posedge clk_sys_in);
    chk8("alert_masked", 8'h01, {7'h00, alert_n});
    rd(8'h42, 8'h20, "status");
    drain(8'h01);
    wb(1'b1, 8'h74, 8'h00);
    fork
      thermal_event_pin_partner_inst.pulse(12);
      begin
        repeat (4) @(posedge clk_sys_in);
        rd(8'h79, 8'h01, "timer_mid");
      end
    join
    repeat (3) @(posedge clk_sys_in);
    drain(8'h01);
    wb(1'b1, 8'h7d, 8'h02);
    wb(1'b1, 8'h75, 8'h20);
    shared_n <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    shared_n <= 1'b1;
    repeat (6) @(posedge clk_sys_in);
    chk8("alert_shared", 8'h01, {7'h00, alert_n});
    rd(8'h42, 8'h20, "status_shared");
    drain(8'h01);
    wb(1'b1, 8'h75, 8'h00);
    wb(1'b1, 8'h7d, 8'h00);
    wb(1'b1, 8'h7a, 8'h01);
    thermal_event_pin_partner_inst.pulse(12);
    rd(8'h42, 8'h00, "status");
    thermal_event_pin_partner_inst.pulse(16);
    rd(8'h42, 8'h20, "status");
    chk8("alert", 8'h00, {7'h00, alert_n});
    drain(8'h03);
    thermal_event_pin_partner_inst.pulse(2100);
    drain(8'hff);
    fan(8'h06, 8'h00, 8'h00, 1'b1, 1'b0, 8'hff);
    fan(8'h06, 8'h08, 8'h00, 1'b1, 1'b0, 8'h80);
    fan(8'h02, 8'h00, 8'h00, 1'b1, 1'b0, 8'h40);
    fan(8'h06, 8'h00, 8'h00, 1'b0, 1'b0, 8'h40);
    fan(8'h06, 8'h04, 8'h00, 1'b1, 1'b0, 8'h40);
    fan(8'h06, 8'h00, 8'h00, 1'b1, 1'b1, 8'h40);
    fan(8'h06, 8'h00, 8'h08, 1'b1, 1'b1, 8'hff);
    fan_duty_in <= 8'h33;
    repeat (3) @(posedge clk_sys_in);
    chk8("duty_pass", 8'h33, fan_duty_out);
    wb(1'b1, 8'h78, 8'h02);
    wb(1'b1, 8'h7a, 8'hff);
    wb(1'b1, 8'h6a, 8'h50);
    wb(1'b1, 8'h6b, 8'h50);
    wb(1'b1, 8'h6c, 8'h50);
    wb(1'b1, 8'h7c, 8'he0);
    ts(0, {8'h50, 2'b00}, 1'b0);
    ts(0, {8'h50, 2'b01}, 1'b1);
    ts(0, {8'h50, 2'b01}, 1'b1);
    ts(1, {8'h50, 2'b10}, 1'b1);
    ts(0, {8'h50, 2'b00}, 1'b1);
    ts(1, {8'h50, 2'b00}, 1'b0);
    wb(1'b1, 8'h7c, 8'h20);
    ts(1, {8'h50, 2'b01}, 1'b0);
    ts(1, {8'h50, 2'b00}, 1'b0);
    wb(1'b1, 8'h7c, 8'h80);
    ts(2, {8'h50, 2'b01}, 1'b1);
    ts(2, {8'h50, 2'b00}, 1'b0);
    wb(1'b1, 8'h7c, 8'h20);
    wb(1'b1, 8'h6a, 8'h80);
    ts(0, {8'h81, 2'b00}, 1'b0);
    wb(1'b1, 8'h7c, 8'h21);
    wb(1'b1, 8'h6a, 8'h01);
    ts(0, {8'h02, 2'b00}, 1'b0);
    wb(1'b1, 8'h6a, 8'h02);
    ts(0, {8'h02, 2'b01}, 1'b1);
    ts(0, {8'h02, 2'b00}, 1'b0);
    wb(1'b1, 8'h7d, 8'h04);
    ts(0, {8'h02, 2'b01}, 1'b0);
    wb(1'b1, 8'h11, 8'h01);
    repeat (4) @(posedge clk_sys_in);
    chk8("pin_oe", 8'h01, {7'h00, pin_oe});
    chk8("pin_val", 8'h00, {7'h00, pin_val});
    wb(1'b1, 8'h11, 8'h00);
    repeat (4) @(posedge clk_sys_in);
    chk8("pin_oe", 8'h00, {7'h00, pin_oe});
    tally_and_finish;
  end
endmodule // tb_thermal_event_monitor
